// ==== pkg/smc_regs.svh ====
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SMC_ADDR_W          6
`define SMC_CTRL_OFFSET     6'h35
`define SMC_CTRL_RESET      8'h00
`define SMC_DOZE_ARM_BIT    7
`define SMC_MODE_HI_BIT     6
`define SMC_MODE_LO_BIT     4
`define SMC_UNMAPPED_READ   8'h00

// ----------------------------------------------------------------------
// Mode-select encodings
// ----------------------------------------------------------------------
`define SMC_MODE_IDLE       3'h0
`define SMC_MODE_ADC_NR     3'h1
`define SMC_MODE_PWR_DOWN   3'h2
`define SMC_MODE_PWR_SAVE   3'h3
`define SMC_MODE_STANDBY    3'h6

`endif

// ==== pkg/smc_pkg.sv ====
package smc_pkg;

    typedef enum logic [2:0] {
        SMC_IDLE,
        SMC_ADC_NR,
        SMC_PWR_DOWN,
        SMC_PWR_SAVE,
        SMC_STANDBY
    } smc_mode_type;

    typedef struct packed {
        logic cpu_clk_en;
        logic io_clk_en;
        logic sram_clk_en;
        logic timer_clk_en;
        logic spi_clk_en;
        logic irq_clk_en;
        logic adc_clk_en;
        logic async_timer_en;
        logic main_osc_en;
    } smc_gate_type;

endpackage

// ==== rtl/smc_sleep_ctrl.sv ====
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "smc_regs.svh"

// ----------------------------------------------------------------------
// Function
// ----------------------------------------------------------------------
module smc_sleep_ctrl (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic [`SMC_ADDR_W-1:0]  reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic                    sleep_instr,
    input  wire logic                    wake_irq,
    output smc_pkg::smc_gate_type        gates,
    output logic                         asleep
);

    // ------------------------------------------------------------------
    // Wake request synchroniser
    // ------------------------------------------------------------------
    // The wake line comes from interrupt pins, so it crosses in.
    logic wake_s1_r;
    logic wake_s2_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else begin
            wake_s1_r <= wake_irq;
            wake_s2_r <= wake_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [2:0] pick;

    assign pick = ctrl_r[`SMC_MODE_HI_BIT:`SMC_MODE_LO_BIT];

    always_comb begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = `SMC_UNMAPPED_READ;
        if (reg_wr && reg_addr == `SMC_CTRL_OFFSET) begin
            ctrl_nxt = reg_wdata;
        end
        if (reg_rd && reg_addr == `SMC_CTRL_OFFSET) begin
            rdata_nxt = ctrl_r;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r  <= `SMC_CTRL_RESET;
            rdata_r <= `SMC_UNMAPPED_READ;
        end else begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Reserved encodings are not a sixth mode: a sleep instruction
    // with one of them selected is ignored, keeping exactly five.
    smc_pkg::smc_mode_type pick_mode;
    logic                  pick_ok;

    always_comb begin
        pick_ok   = 1'b1;
        pick_mode = smc_pkg::SMC_IDLE;
        case (pick)
            `SMC_MODE_IDLE:     pick_mode = smc_pkg::SMC_IDLE;
            `SMC_MODE_ADC_NR:   pick_mode = smc_pkg::SMC_ADC_NR;
            `SMC_MODE_PWR_DOWN: pick_mode = smc_pkg::SMC_PWR_DOWN;
            `SMC_MODE_PWR_SAVE: pick_mode = smc_pkg::SMC_PWR_SAVE;
            `SMC_MODE_STANDBY:  pick_mode = smc_pkg::SMC_STANDBY;
            default:            pick_ok   = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Sleep state and clock gates
    // ------------------------------------------------------------------
    smc_pkg::smc_mode_type mode_r;
    smc_pkg::smc_mode_type mode_nxt;
    logic                  asleep_r;
    logic                  asleep_nxt;
    smc_pkg::smc_gate_type gates_r;
    smc_pkg::smc_gate_type gates_nxt;
    logic                  enter;

    assign enter = sleep_instr && ctrl_r[`SMC_DOZE_ARM_BIT] && pick_ok
                   && !asleep_r;

    always_comb begin
        mode_nxt   = mode_r;
        asleep_nxt = asleep_r;
        if (asleep_r && wake_s2_r) begin
            asleep_nxt = 1'b0;
        end else if (enter) begin
            asleep_nxt = 1'b1;
            mode_nxt   = pick_mode;
        end
        gates_nxt = '1;
        if (asleep_nxt) begin
            gates_nxt = '0;
            case (mode_nxt)
                smc_pkg::SMC_IDLE: begin
                    gates_nxt              = '1;
                    gates_nxt.cpu_clk_en   = 1'b0;
                end
                smc_pkg::SMC_ADC_NR: begin
                    gates_nxt.adc_clk_en     = 1'b1;
                    gates_nxt.async_timer_en = 1'b1;
                    gates_nxt.main_osc_en    = 1'b1;
                end
                smc_pkg::SMC_PWR_DOWN: begin
                    gates_nxt = '0;
                end
                smc_pkg::SMC_PWR_SAVE: begin
                    gates_nxt.async_timer_en = 1'b1;
                end
                smc_pkg::SMC_STANDBY: begin
                    gates_nxt.main_osc_en = 1'b1;
                end
                default: gates_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_r   <= smc_pkg::SMC_IDLE;
            asleep_r <= 1'b0;
            gates_r  <= '1;
        end else begin
            mode_r   <= mode_nxt;
            asleep_r <= asleep_nxt;
            gates_r  <= gates_nxt;
        end
    end

    assign gates  = gates_r;
    assign asleep = asleep_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    idle_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && mode_r == smc_pkg::SMC_IDLE |->
            !gates_r.cpu_clk_en && gates_r.sram_clk_en
            && gates_r.timer_clk_en && gates_r.spi_clk_en
            && gates_r.irq_clk_en)
        else $error("Idle mode gates wrong");

    pdown_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && mode_r == smc_pkg::SMC_PWR_DOWN |-> gates_r == '0)
        else $error("Power-down left a clock running");

    psave_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && mode_r == smc_pkg::SMC_PWR_SAVE |->
            gates_r.async_timer_en && !gates_r.main_osc_en
            && !gates_r.cpu_clk_en)
        else $error("Power-save gates wrong");

    adcnr_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && mode_r == smc_pkg::SMC_ADC_NR |->
            gates_r.adc_clk_en && gates_r.async_timer_en
            && !gates_r.io_clk_en && !gates_r.cpu_clk_en)
        else $error("Noise reduction gates wrong");

    stby_gates_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && mode_r == smc_pkg::SMC_STANDBY |->
            gates_r.main_osc_en && !gates_r.cpu_clk_en
            && !gates_r.async_timer_en)
        else $error("Standby gates wrong");

    bad_pick_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !asleep_r && sleep_instr && !pick_ok |=> !asleep_r)
        else $error("Reserved mode entered sleep");

    unarmed_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !asleep_r && !ctrl_r[`SMC_DOZE_ARM_BIT] |=> !asleep_r)
        else $error("Sleep entered without arm bit");

    armed_enter_a: assert property (
        @(posedge clk) disable iff (!resetn)
        enter |=> asleep_r && !gates_r.cpu_clk_en)
        else $error("Armed sleep not entered");

    awake_run_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $fell(asleep_r) |-> gates_r == '1)
        else $error("Wake left clocks gated");

    // A sleeping controller leaves its mode only on a synchronised wake or a reset.
    sleep_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && !wake_s2_r |=> asleep_r && $stable(mode_r))
        else $error("Sleep left without wake");

    wake_exit_a: assert property (
        @(posedge clk) disable iff (!resetn)
        asleep_r && wake_s2_r |=> !asleep_r)
        else $error("Wake did not end sleep");

endmodule

// ==== testbench/smc_core_model.sv ====
`timescale 1ns/1ps
`include "smc_regs.svh"
// ----------------------------------------------------------------------
// Core side of the register port and the sleep instruction
// ----------------------------------------------------------------------
module smc_core_model (
    input  wire logic       clk,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata,
    output logic            sleep_instr
);
    initial begin
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_instr = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // The arm bit and mode are written before the instruction issues.
    task automatic doze(input logic arm, input logic [2:0] m);
        wr(`SMC_CTRL_OFFSET, {arm, m, 4'h5});
        sleep_instr <= 1'b1;
        @(posedge clk);
        sleep_instr <= 1'b0;
    endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "smc_regs.svh"
module tb;
    logic                  clk;
    logic                  resetn;
    logic                  wake_irq;
    logic                  asleep;
    logic [5:0]            reg_addr;
    logic [7:0]            reg_wdata;
    logic [7:0]            reg_rdata;
    logic [7:0]            d;
    logic                  reg_wr;
    logic                  reg_rd;
    logic                  sleep_instr;
    smc_pkg::smc_gate_type gates;
    int                    n_fail;
    int                    comparisons;
    logic [2:0] mode_tab [5] = '{`SMC_MODE_IDLE, `SMC_MODE_PWR_DOWN,
        `SMC_MODE_PWR_SAVE, `SMC_MODE_ADC_NR, `SMC_MODE_STANDBY};
    logic [8:0] gate_tab [5] = '{9'h0FF, 9'h000, 9'h002, 9'h007, 9'h001};
    logic [2:0] bad_tab [3] = '{3'h4, 3'h5, 3'h7};

    smc_core_model core (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_instr(sleep_instr));
    smc_sleep_ctrl uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_instr(sleep_instr),
        .wake_irq(wake_irq), .gates(gates), .asleep(asleep));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [8:0] e, logic [8:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Wake is synchronised, so asleep must fall after exactly three edges.
    task automatic wake();
        @(posedge clk) wake_irq <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("asleep_hold", 9'h001, {8'h00, asleep});
        @(posedge clk);
        #1 chk("asleep_wake", 9'h000, {8'h00, asleep});
        chk("gates_wake", 9'h1FF, gates);
        @(posedge clk) wake_irq <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Enter one mode, check its gates and the kept register, then wake.
    task automatic mode_pass(input int i);
        core.doze(1'b1, mode_tab[i]);
        #1 chk("gates_mode", gate_tab[i], gates);
        chk("asleep", 9'h001, {8'h00, asleep});
        core.rd(`SMC_CTRL_OFFSET, d);
        chk("ctrl", {2'b01, mode_tab[i], 4'h5}, {1'b0, d});
        wake();
    endtask

    initial begin
        n_fail = 0;
        comparisons = 0;
        resetn = 1'b0;
        wake_irq = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        core.rd(`SMC_CTRL_OFFSET, d);
        chk("ctrl_rst", {1'b0, `SMC_CTRL_RESET}, {1'b0, d});
        chk("gates_rst", 9'h1FF, gates);
        core.wr(6'h00, 8'hA5);
        core.rd(6'h00, d);
        chk("unmapped", 9'h000, {1'b0, d});
        mode_pass(0);
        mode_pass(1);
        mode_pass(2);
        mode_pass(3);
        mode_pass(4);
        core.doze(1'b0, `SMC_MODE_PWR_DOWN);
        #1 chk("no_arm", 9'h000, {8'h00, asleep});
        for (int i = 0; i < 3; i++) begin
            core.doze(1'b1, bad_tab[i]);
            #1 chk("reserved", 9'h1FF, gates);
        end
        // A hardware reset must also wake a powered-down controller.
        core.doze(1'b1, `SMC_MODE_PWR_DOWN);
        #1 chk("pd_entered", 9'h001, {8'h00, asleep});
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("asleep_rst", 9'h000, {8'h00, asleep});
        chk("gates_rst2", 9'h1FF, gates);
        @(posedge clk) resetn <= 1'b1;
        core.rd(`SMC_CTRL_OFFSET, d);
        chk("ctrl_rst2", {1'b0, `SMC_CTRL_RESET}, {1'b0, d});
        stop_test();
    end
endmodule
